// File: ocqt_host_model.sv
// bus controller model: sends command pulses and reads the reply byte
module ocqt_host_model
	import ocqt_pkg::*;
(
	input wire logic mclk,
	input wire logic cmd_ready,
	input wire logic talk_valid,
	input wire logic [7:0] talk_data,
	output ocqt_cmd_t cmd,
	output logic talk
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		cmd = '0;
		talk = 1'b0;
	end
	// one-cycle command; held back while locked unless told to insist or it is device clear
	task automatic issue(input int idx, input bit insist);
		ocqt_cmd_t c;
		c = '0;
		c[idx] = 1'b1;
		if (!insist && cmd_ready !== 1'b1 && idx != 5) begin
			return;
		end
		@(posedge mclk) cmd <= c;
		@(posedge mclk) cmd <= '0;
	endtask
	// address the device to talk and take the byte it answers with
	task automatic fetch(output logic [7:0] d);
		@(posedge mclk) talk <= 1'b1;
		@(posedge mclk) talk <= 1'b0;
		#1;
		d = (talk_valid === 1'b1) ? talk_data : 8'h00;
	endtask
endmodule // ocqt_host_model

// File: ocqt_pending.sv
// pending overlapped operation tracker producing the no-operation-pending flag
module ocqt_pending
	import ocqt_pkg::*;
(
	input wire logic mclk,
	input wire logic reset,
	input wire logic cancel,
	input wire ocqt_cmd_t cmd,
	input wire ocqt_trig_t trig,
	input wire logic cont_enable,
	output logic no_op_pending
);
	logic init_pend;
	logic trig_pend;
	logic next_init_pend;
	logic next_trig_pend;
	logic init_start;
	logic trig_done;

	// initiate pending until the model is idle; abort completes it
	assign init_start = cmd.initiate | cmd.cont_on;
	assign next_init_pend = init_start ? 1'b1 : ((trig.model_idle | cmd.abort) ? 1'b0 : init_pend);
	// trigger finished at device action or a wait at a control source
	assign trig_done = trig.action_done | trig.source_wait;
	assign next_trig_pend = cmd.trigger ? 1'b1 : (trig_done ? 1'b0 : trig_pend);
	// flag true only when nothing of the three overlapped kinds is outstanding
	assign no_op_pending = ~init_pend & ~trig_pend;

	// pending state, cleared by power-up or cancel
	always_ff @(posedge mclk) begin
		if (reset | cancel) begin
			init_pend <= 1'b0;
			trig_pend <= 1'b0;
		end else begin
			init_pend <= next_init_pend;
			trig_pend <= next_trig_pend;
		end
	end

	a_cancel_clears: assert property (@(posedge mclk) disable iff (reset)
		cancel |=> no_op_pending) else $error("cancel left an operation pending");
	a_init_holds: assert property (@(posedge mclk) disable iff (reset)
		(init_start & ~cancel) |=> !no_op_pending) else $error("initiate not counted");
	a_trig_holds: assert property (@(posedge mclk) disable iff (reset)
		(cmd.trigger & ~cancel) |=> !no_op_pending) else $error("trigger not counted");
	// continuous flag is unused; abort completes the initiate in continuous mode too, and no re-entry is tracked
	logic unused_cont;
	assign unused_cont = cont_enable;
endmodule // ocqt_pending

// File: ocqt_pkg.sv
// package: constants, states and carriers for the operation-complete query tracker
package ocqt_pkg;
	// register offsets
	localparam logic [3:0] OCQT_REG_CTRL = 4'h0;
	localparam logic [3:0] OCQT_REG_STATUS = 4'h1;
	localparam logic [3:0] OCQT_REG_IRQ_STAT = 4'h2;
	localparam logic [3:0] OCQT_REG_IRQ_MASK = 4'h3;
	localparam logic [3:0] OCQT_REG_REPLY = 4'h4;
	// control field positions
	localparam int OCQT_CTRL_CONT_BIT = 0;
	// status byte position of message available
	localparam int OCQT_MAV_BIT = 4;
	// interrupt status bit positions
	localparam int OCQT_IRQ_REPLY_BIT = 0;
	localparam int OCQT_IRQ_LOCK_BIT = 1;
	// reset values
	localparam logic [7:0] OCQT_CTRL_RESET = 8'h00;
	localparam logic [1:0] OCQT_MASK_RESET = 2'h0;
	// reply character
	localparam logic [7:0] OCQT_ASCII_ONE = 8'h31;

	typedef enum logic [1:0] {
		OCQT_QUERY_IDLE_STATE = 2'b01,
		OCQT_QUERY_ACTIVE_STATE = 2'b10
	} ocqt_state_t;

	// command strobes from the parser, one cycle each
	typedef struct packed {
		logic query;
		logic clear_status;
		logic reset_cmd;
		logic device_clear;
		logic initiate;
		logic cont_on;
		logic cont_off;
		logic trigger;
		logic abort;
	} ocqt_cmd_t;

	// trigger model status, same clock
	typedef struct packed {
		logic model_idle;
		logic action_done;
		logic source_wait;
	} ocqt_trig_t;

	// register port
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} ocqt_bus_t;
endpackage

// File: ocqt_tracker.sv
// top: operation-complete query tracker with output queue, status byte and register port

//////////////////////////////////////////////////////////////////////////////
// Function
// - Power-up, clear-status and reset put the tracker in the idle query state with nothing pending.
// - Only initiate, continuous-initiate-on and trigger count as overlapped operations.
// - Executing the query always moves the tracker to the active query state.
// - In the active state the no-operation-pending flag is checked every cycle.
// - When the flag is true in the active state a one is queued, message available sets, and idle returns.
// - With nothing pending the reply is queued at once after the query.
// - Initiate operations stay pending until the trigger model is idle.
// - A trigger finishes on device action done or a wait at a control source.
// - Abort completes the initiate; continuous mode is ignored and nothing re-enters the trigger model.
// - While a query waits, no further commands except device clear are accepted.
// - A device clear releases the lock and commands are accepted again.
// - When addressed to talk the queued one is sent to the controller.
// - Message available shows at bit four of the status byte.
// - The reset command cancels a reply still owed to an earlier query.
module ocqt_tracker
	import ocqt_pkg::*;
(
	input wire logic mclk,
	input wire logic reset,
	input wire ocqt_cmd_t cmd,
	input wire ocqt_trig_t trig,
	input wire logic talk,
	input wire ocqt_bus_t bus,
	output logic [7:0] rdata,
	output logic cmd_ready,
	output logic talk_valid,
	output logic [7:0] talk_data,
	output logic [7:0] status_byte,
	output logic irq
);
	//////////////////////////////////////////////////////////////////////////
	// state and storage
	ocqt_state_t state;
	ocqt_state_t next_state;
	logic queue_full;
	logic next_queue_full;
	logic [7:0] queue_data;
	logic [7:0] ctrl;
	logic [1:0] irq_stat;
	logic [1:0] irq_mask;
	logic [1:0] next_irq_stat;
	logic [7:0] rdata_q;
	logic [7:0] talk_q;
	logic talk_v;
	logic no_op_pending;
	logic cancel;
	logic query_go;
	logic reply_push;
	logic talk_pop;
	logic locked;
	ocqt_cmd_t cmd_ok;

	//////////////////////////////////////////////////////////////////////////
	// command gating: lock while waiting, device clear always passes
	assign locked = (state == OCQT_QUERY_ACTIVE_STATE);
	assign cmd_ready = ~locked;
	always_comb begin
		cmd_ok = cmd;
		if (locked) begin
			cmd_ok = '0;
			cmd_ok.device_clear = cmd.device_clear;
		end
	end
	assign cancel = cmd_ok.clear_status | cmd_ok.reset_cmd | cmd_ok.device_clear;
	assign query_go = cmd_ok.query & ~cancel;

	ocqt_pending u_pending (
		.mclk(mclk),
		.reset(reset),
		.cancel(cancel),
		.cmd(cmd_ok),
		.trig(trig),
		.cont_enable(ctrl[OCQT_CTRL_CONT_BIT]),
		.no_op_pending(no_op_pending)
	);

	//////////////////////////////////////////////////////////////////////////
	// query state machine
	assign reply_push = (state == OCQT_QUERY_ACTIVE_STATE) & no_op_pending & ~cancel;
	always_comb begin
		next_state = state;
		unique case (state)
			OCQT_QUERY_IDLE_STATE: begin
				if (query_go) begin
					next_state = OCQT_QUERY_ACTIVE_STATE;
				end
			end
			OCQT_QUERY_ACTIVE_STATE: begin
				if (cancel | reply_push) begin
					next_state = OCQT_QUERY_IDLE_STATE;
				end
			end
			default: next_state = OCQT_QUERY_IDLE_STATE;
		endcase
	end
	always_ff @(posedge mclk) begin
		if (reset) begin
			state <= OCQT_QUERY_IDLE_STATE;
		end else begin
			state <= next_state;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// output queue of one entry; reset command drops an owed reply
	assign talk_pop = talk & queue_full & ~talk_v;
	assign next_queue_full = reply_push ? 1'b1 : ((talk_pop | cmd_ok.reset_cmd | cmd_ok.device_clear) ? 1'b0 : queue_full);
	always_ff @(posedge mclk) begin
		if (reset) begin
			queue_full <= 1'b0;
			queue_data <= 8'h00;
		end else begin
			queue_full <= next_queue_full;
			if (reply_push) begin
				queue_data <= OCQT_ASCII_ONE;
			end
		end
	end

	// talk transfer: one cycle pulse carrying the queued byte
	always_ff @(posedge mclk) begin
		if (reset) begin
			talk_v <= 1'b0;
			talk_q <= 8'h00;
		end else begin
			talk_v <= talk_pop;
			if (talk_pop) begin
				talk_q <= queue_data;
			end
		end
	end
	assign talk_valid = talk_v;
	assign talk_data = talk_q;

	// status byte with message available at its bit
	always_comb begin
		status_byte = 8'h00;
		status_byte[OCQT_MAV_BIT] = queue_full;
	end

	//////////////////////////////////////////////////////////////////////////
	// interrupt status: set wins over write-one-clear
	assign next_irq_stat = (irq_stat & ~((bus.wr && bus.addr == OCQT_REG_IRQ_STAT) ? bus.wdata[1:0] : 2'h0))
		| {locked & cmd.query, reply_push};
	always_ff @(posedge mclk) begin
		if (reset) begin
			irq_stat <= 2'h0;
		end else begin
			irq_stat <= next_irq_stat;
		end
	end
	assign irq = |(irq_stat & irq_mask);

	//////////////////////////////////////////////////////////////////////////
	// register writes
	always_ff @(posedge mclk) begin
		if (reset) begin
			ctrl <= OCQT_CTRL_RESET;
			irq_mask <= OCQT_MASK_RESET;
		end else if (bus.wr) begin
			if (bus.addr == OCQT_REG_CTRL) begin
				ctrl <= bus.wdata;
			end
			if (bus.addr == OCQT_REG_IRQ_MASK) begin
				irq_mask <= bus.wdata[1:0];
			end
		end
	end

	// register read mux, data one cycle after the strobe
	logic [7:0] rd_mux;
	assign rd_mux = (bus.addr == OCQT_REG_CTRL) ? ctrl :
		(bus.addr == OCQT_REG_STATUS) ? {status_byte[7:3], locked, no_op_pending, queue_full} :
		(bus.addr == OCQT_REG_IRQ_STAT) ? {6'h00, irq_stat} :
		(bus.addr == OCQT_REG_IRQ_MASK) ? {6'h00, irq_mask} :
		(bus.addr == OCQT_REG_REPLY) ? queue_data : 8'h00;
	always_ff @(posedge mclk) begin
		if (reset) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= bus.rd ? rd_mux : 8'h00;
		end
	end
	assign rdata = rdata_q;

	//////////////////////////////////////////////////////////////////////////
	// assertions
	a_query_active: assert property (@(posedge mclk) disable iff (reset)
		(query_go && state == OCQT_QUERY_IDLE_STATE) |=> state == OCQT_QUERY_ACTIVE_STATE)
		else $error("query did not enter active state");
	a_reply_idle: assert property (@(posedge mclk) disable iff (reset)
		reply_push |=> (state == OCQT_QUERY_IDLE_STATE && queue_full && queue_data == OCQT_ASCII_ONE))
		else $error("reply not queued");
	a_immediate_reply: assert property (@(posedge mclk) disable iff (reset)
		(query_go && state == OCQT_QUERY_IDLE_STATE && no_op_pending && !cmd.initiate && !cmd.cont_on
		&& !cmd.trigger) |=> ##1 queue_full)
		else $error("idle query reply late");
	a_wait_pending: assert property (@(posedge mclk) disable iff (reset)
		(locked && !no_op_pending && !cancel) |=> locked)
		else $error("left active while pending");
	a_lock_cmds: assert property (@(posedge mclk) disable iff (reset)
		locked |-> (!cmd_ready && !cmd_ok.query && !cmd_ok.initiate))
		else $error("command accepted while locked");
	a_dcl_unlock: assert property (@(posedge mclk) disable iff (reset)
		cmd.device_clear |=> (cmd_ready && !queue_full))
		else $error("device clear did not unlock");
	a_talk_one: assert property (@(posedge mclk) disable iff (reset)
		talk_pop |=> (talk_valid && talk_data == OCQT_ASCII_ONE && !queue_full))
		else $error("talk did not send reply");
	a_mav_bit: assert property (@(posedge mclk) disable iff (reset)
		status_byte[OCQT_MAV_BIT] == queue_full && status_byte[3:0] == 4'h0)
		else $error("message available bit wrong");
	a_rst_cancel: assert property (@(posedge mclk) disable iff (reset)
		(cmd_ok.reset_cmd && !reply_push) |=> (!queue_full && state == OCQT_QUERY_IDLE_STATE))
		else $error("reset left reply owed");
	c_immediate: cover property (@(posedge mclk) disable iff (reset) query_go ##1 reply_push);
	c_waited: cover property (@(posedge mclk) disable iff (reset) locked [*3] ##1 reply_push);
	c_dcl: cover property (@(posedge mclk) disable iff (reset) locked ##1 cmd.device_clear);
	c_talk: cover property (@(posedge mclk) disable iff (reset) reply_push ##[1:20] talk_valid);
endmodule // ocqt_tracker

// File: tb_top.sv
// testbench: commands, trigger status and register traffic for the tracker
module tb_top import ocqt_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int QRY = 8, CLS = 7, RST = 6, DCL = 5, INI = 4, CON = 3, COF = 2, TRG = 1, ABT = 0;
	logic mclk, reset, talk, cmd_ready, talk_valid, irq;
	ocqt_cmd_t cmd;
	ocqt_trig_t trig;
	ocqt_bus_t bus;
	logic [7:0] rdata, talk_data, status_byte, got;
	int failures = 0, num_checks = 0, seed = 32'hf9c6, t;
	ocqt_tracker uut(.mclk(mclk), .reset(reset), .cmd(cmd), .trig(trig), .talk(talk), .bus(bus), .rdata(rdata),
		.cmd_ready(cmd_ready), .talk_valid(talk_valid), .talk_data(talk_data), .status_byte(status_byte), .irq(irq));
	ocqt_host_model host(.mclk(mclk), .cmd_ready(cmd_ready), .talk_valid(talk_valid), .talk_data(talk_data),
		.cmd(cmd), .talk(talk));
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	//////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
		num_checks++;
		if (g !== e) begin
			$display("unexpected at %0t: %s", $time, m);
			failures++;
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk) bus <= '{a, d, 1'b1, 1'b0};
		@(posedge mclk) bus <= '0;
		#1;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e, input string m);
		@(posedge mclk) bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge mclk) bus <= '0;
		#1;
		chk(rdata, e, m);
	endtask
	// bounded wait for the reply to show in the status byte
	task automatic wait_reply(input int n);
		int k;
		for (k = 0; k < n; k++) begin
			@(posedge mclk);
			#1;
			if (status_byte[4] === 1'b1) break;
		end
		chk(status_byte, 8'h10, "reply missing");
		if (status_byte !== 8'h10) report_and_stop();
	endtask
	// no reply may appear while work is outstanding
	task automatic quiet(input int n);
		int k;
		for (k = 0; k < n; k++) begin
			@(posedge mclk);
			#1;
			chk(status_byte, 8'h00, "early reply");
		end
		chk({7'h00, cmd_ready}, 8'h00, "not locked");
	endtask
	task automatic trig_pulse(input ocqt_trig_t v);
		@(posedge mclk) trig <= v;
		@(posedge mclk) trig <= '0;
	endtask
	task automatic drain();
		host.fetch(got);
		chk(got, OCQT_ASCII_ONE, "talk byte");
		chk(status_byte, 8'h00, "queue not emptied");
	endtask
	//////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		reset = 1'b1;
		trig = '0;
		bus = '0;
		repeat (8) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		#1;
		chk({status_byte[7:1], cmd_ready}, 8'h01, "after reset");
		rd(OCQT_REG_STATUS, 8'h02, "status reg");
		rd(OCQT_REG_IRQ_MASK, 8'h00, "mask reset");
		wr(OCQT_REG_CTRL, 8'hA5);
		rd(OCQT_REG_CTRL, 8'hA5, "ctrl");
		rd(4'hF, 8'h00, "unmapped");
		$display("test registers done");
		host.issue(QRY, 0);
		wait_reply(4);
		rd(OCQT_REG_STATUS, 8'h13, "status reg reply");
		rd(OCQT_REG_REPLY, OCQT_ASCII_ONE, "reply reg");
		chk({7'h00, irq}, 8'h00, "irq masked");
		wr(OCQT_REG_IRQ_MASK, 8'h03);
		chk({7'h00, irq}, 8'h01, "irq unmasked");
		wr(OCQT_REG_IRQ_STAT, 8'h01);
		chk({7'h00, irq}, 8'h00, "irq cleared");
		drain();
		$display("test immediate done");
		for (t = 0; t < 8; t++) begin
			host.issue((t % 2) ? TRG : INI, 0);
			host.issue(QRY, 0);
			quiet(2 + ($random(seed) & 15));
			if (t % 2) trig_pulse(($random(seed) & 1) ? 3'b010 : 3'b001);
			else trig_pulse(3'b100);
			wait_reply(6);
			drain();
		end
		$display("test overlapped done");
		host.issue(INI, 0);
		host.issue(CLS, 0);
		host.issue(COF, 0);
		host.issue(QRY, 0);
		wait_reply(4);
		drain();
		host.issue(QRY, 0);
		wait_reply(4);
		host.issue(RST, 0);
		repeat (2) @(posedge mclk);
		#1;
		chk(status_byte, 8'h00, "reply kept");
		$display("test clear and reset done");
		host.issue(CON, 0);
		host.issue(ABT, 0);
		host.issue(TRG, 0);
		host.issue(QRY, 0);
		quiet(3 + ($random(seed) & 7));
		trig_pulse(3'b010);
		wait_reply(6);
		drain();
		$display("test abort done");
		wr(OCQT_REG_IRQ_STAT, 8'h03);
		host.issue(CON, 0);
		host.issue(QRY, 0);
		quiet(20);
		host.issue(QRY, 1);
		rd(OCQT_REG_IRQ_STAT, 8'h02, "refused query");
		chk({7'h00, irq}, 8'h01, "irq refused");
		host.issue(DCL, 0);
		@(posedge mclk);
		#1;
		chk({status_byte[7:1], cmd_ready}, 8'h01, "after device clear");
		host.issue(QRY, 0);
		wait_reply(4);
		drain();
		$display("test lock done");
		report_and_stop();
	end
endmodule // tb_top
